// >>> design/xce_exec.sv
// Extended execution unit: sign extend, test, exclusive OR, 20-bit add,
// branch, call and return, started and observed over AHB-Lite.
// Assumes a 16-bit memory that acknowledges each request within a few cycles.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module xce_exec #(
  parameter int DATA_W = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory port
  output xce_pkg::xce_mem_req_t mem_req,
  input wire xce_pkg::xce_mem_rsp_t mem_rsp,
  // Status
  output logic busy
);
  // The datapath below is written for 20 bits only.
  if (DATA_W != 20) begin : g_width_check
    $error("xce_exec supports only a 20-bit data path");
  end

  typedef struct packed {
    xce_pkg::xce_state_t st;
    logic [31:0] ctrl;
    logic [19:0] src;
    logic [19:0] dst;
    logic [19:0] res;
    logic [19:0] pc;
    logic [19:0] sp;
    logic [19:0] ptr;
    logic [19:0] tmp;
    logic [19:0] ea;
    logic [15:0] status;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    xce_pkg::xce_mem_req_t mreq;
  } xce_regs_t;

  xce_regs_t st_r;
  xce_regs_t st_nxt;

  xce_pkg::xce_op_t op;
  xce_pkg::xce_size_t sz;
  xce_pkg::xce_tmode_t tm;
  logic reg_dst;
  logic [19:0] ofs;
  logic [19:0] mask;
  logic [19:0] topbit;
  logic [19:0] ext7;
  logic [19:0] xr;
  logic [20:0] sum;
  logic [19:0] tst;

  assign op = xce_pkg::xce_op_t'(st_r.ctrl[xce_pkg::CTRL_OP_LSB +: 4]);
  assign sz = xce_pkg::xce_size_t'(st_r.ctrl[xce_pkg::CTRL_SIZE_LSB +: 2]);
  assign tm = xce_pkg::xce_tmode_t'(st_r.ctrl[xce_pkg::CTRL_MODE_LSB +: 3]);
  assign reg_dst = st_r.ctrl[xce_pkg::CTRL_REGDST_BIT];
  // Offset of the control word in its data phase; signed 16 bits, so the
  // reach is limited to +/-32K.
  assign ofs = {{4{hwdata[31]}}, hwdata[xce_pkg::CTRL_OFS_LSB +: 16]};

  // Width mask and sign position follow the size suffix.
  always_comb begin
    case (sz)
      xce_pkg::SZ_BYTE: begin
        mask = 20'h000FF;
        topbit = 20'h00080;
      end
      xce_pkg::SZ_WORD: begin
        mask = 20'h0FFFF;
        topbit = 20'h08000;
      end
      default: begin
        mask = 20'hFFFFF;
        topbit = 20'h80000;
      end
    endcase
  end

  // Bit 7 copied upward, then cut to width.
  assign ext7 = {{12{st_r.dst[7]}}, st_r.dst[7:0]} &
                ((reg_dst || sz == xce_pkg::SZ_ADDR) ? 20'hFFFFF : 20'h0FFFF);
  assign xr = (st_r.src ^ st_r.dst) & mask;
  assign sum = {1'b0, st_r.src} + {1'b0, st_r.dst};
  // All-ones plus one at width gives the destination itself.
  assign tst = (st_r.dst + (xce_pkg::ALL_ONES20 & mask) + 20'h00001) & mask;

  always_comb begin
    logic [19:0] r;
    logic [19:0] tgt;
    logic zf;
    st_nxt = st_r;
    r = 20'h00000;
    tgt = 20'h00000;
    zf = 1'b0;
    // Bus address phase capture; register access completes one cycle later.
    st_nxt.ap_valid = hsel && htrans[1] && hready;
    st_nxt.ap_write = hwrite;
    st_nxt.ap_addr = haddr[7:0];
    if (st_r.ap_valid && !st_r.ap_write) begin
      case (st_r.ap_addr)
        xce_pkg::OFS_CTRL: st_nxt.rdata = st_r.ctrl;
        xce_pkg::OFS_SRC: st_nxt.rdata = {12'h000, st_r.src};
        xce_pkg::OFS_DST: st_nxt.rdata = {12'h000, st_r.dst};
        xce_pkg::OFS_RES: st_nxt.rdata = {12'h000, st_r.res};
        xce_pkg::OFS_STATUS: st_nxt.rdata = {16'h0000, st_r.status};
        xce_pkg::OFS_PC: st_nxt.rdata = {12'h000, st_r.pc};
        xce_pkg::OFS_SP: st_nxt.rdata = {12'h000, st_r.sp};
        xce_pkg::OFS_PTR: st_nxt.rdata = {12'h000, st_r.ptr};
        default: st_nxt.rdata = xce_pkg::BUS_UNMAPPED;
      endcase
    end
    if (st_r.ap_valid && st_r.ap_write && st_r.st == xce_pkg::S_IDLE) begin
      case (st_r.ap_addr)
        xce_pkg::OFS_CTRL: st_nxt.ctrl = hwdata;
        xce_pkg::OFS_SRC: st_nxt.src = hwdata[19:0];
        xce_pkg::OFS_DST: st_nxt.dst = hwdata[19:0];
        xce_pkg::OFS_STATUS: st_nxt.status = hwdata[15:0];
        xce_pkg::OFS_PC: st_nxt.pc = hwdata[19:0];
        xce_pkg::OFS_SP: st_nxt.sp = hwdata[19:0];
        xce_pkg::OFS_PTR: st_nxt.ptr = hwdata[19:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    if (st_r.mreq.req && mem_rsp.ack) begin
      st_nxt.mreq.req = 1'b0;
    end
    case (st_r.st)
      xce_pkg::S_IDLE: begin
        // A control write with a non-zero opcode starts the operation.
        if (st_r.ap_valid && st_r.ap_write &&
            st_r.ap_addr == xce_pkg::OFS_CTRL && hwdata[3:0] != 4'h0) begin
          st_nxt.st = xce_pkg::S_EXEC;
          st_nxt.ea = st_r.ptr;
          if (hwdata[3:0] == 4'(xce_pkg::OP_RETURN)) begin
            st_nxt.st = xce_pkg::S_POP_LO;
            st_nxt.ea = st_r.sp;
            st_nxt.mreq = '{1'b1, 1'b0, st_r.sp, 16'h0000};
          end else if (hwdata[3:0] == 4'(xce_pkg::OP_BRANCH) ||
                       hwdata[3:0] == 4'(xce_pkg::OP_CALL)) begin
            // Address instructions take register or immediate values, or read the target from memory.
            case (xce_pkg::xce_tmode_t'(hwdata[10:8]))
              xce_pkg::TM_IMM, xce_pkg::TM_REG: st_nxt.st = xce_pkg::S_EXEC;
              xce_pkg::TM_INDEXED:
                st_nxt.ea = st_r.ptr + ofs;
              xce_pkg::TM_SYMBOLIC:
                st_nxt.ea = st_r.pc + ofs;
              xce_pkg::TM_ABSOLUTE: st_nxt.ea = st_r.src;
              default: st_nxt.ea = st_r.ptr;
            endcase
            if (hwdata[10:8] > 3'b001) begin
              st_nxt.st = xce_pkg::S_RD_LO;
            end
          end else if (!hwdata[12] && (hwdata[3:0] == 4'(xce_pkg::OP_SIGN_EXT)
                       || hwdata[3:0] == 4'(xce_pkg::OP_TEST)
                       || hwdata[3:0] == 4'(xce_pkg::OP_XOR))) begin
            // Memory destination: fetch it from the pointer first.
            st_nxt.st = xce_pkg::S_RD_LO;
          end
        end
      end
      xce_pkg::S_RD_LO: begin
        if (!st_r.mreq.req) begin
          st_nxt.mreq = '{1'b1, 1'b0, st_r.ea, 16'h0000};
        end else if (mem_rsp.ack) begin
          if (op == xce_pkg::OP_BRANCH || op == xce_pkg::OP_CALL) begin
            st_nxt.tmp[15:0] = mem_rsp.rdata;
          end else begin
            st_nxt.dst[15:0] = mem_rsp.rdata;
          end
          st_nxt.st = (op == xce_pkg::OP_BRANCH || op == xce_pkg::OP_CALL ||
                      sz == xce_pkg::SZ_ADDR) ? xce_pkg::S_RD_HI
                                              : xce_pkg::S_EXEC;
        end
      end
      xce_pkg::S_RD_HI: begin
        // Upper bits live in the following word.
        if (!st_r.mreq.req) begin
          st_nxt.mreq = '{1'b1, 1'b0, st_r.ea + xce_pkg::WORD_STEP, 16'h0000};
        end else if (mem_rsp.ack) begin
          if (op == xce_pkg::OP_BRANCH || op == xce_pkg::OP_CALL) begin
            st_nxt.tmp[19:16] = mem_rsp.rdata[3:0];
          end else begin
            st_nxt.dst[19:16] = mem_rsp.rdata[3:0];
          end
          st_nxt.st = xce_pkg::S_EXEC;
          if (tm == xce_pkg::TM_AUTOINC &&
              (op == xce_pkg::OP_BRANCH || op == xce_pkg::OP_CALL)) begin
            st_nxt.ptr = st_r.ptr + xce_pkg::PTR_STEP;
          end
        end
      end
      xce_pkg::S_EXEC: begin
        st_nxt.st = xce_pkg::S_IDLE;
        // Mode bits are never written below.
        case (op)
          xce_pkg::OP_SIGN_EXT: begin
            r = ext7;
            zf = ((r & mask) == 20'h00000) && (ext7 == 20'h00000);
            st_nxt.status[xce_pkg::ST_N] = |(r & topbit);
            st_nxt.status[xce_pkg::ST_Z] = (r == 20'h00000);
            st_nxt.status[xce_pkg::ST_C] = (r != 20'h00000);
            st_nxt.status[xce_pkg::ST_V] = 1'b0;
          end
          xce_pkg::OP_TEST: begin
            r = st_r.dst;
            st_nxt.status[xce_pkg::ST_N] = |(tst & topbit);
            st_nxt.status[xce_pkg::ST_Z] = (tst == 20'h00000);
            st_nxt.status[xce_pkg::ST_C] = 1'b1;
            st_nxt.status[xce_pkg::ST_V] = 1'b0;
          end
          xce_pkg::OP_XOR: begin
            r = xr;
            st_nxt.status[xce_pkg::ST_N] = |(xr & topbit);
            st_nxt.status[xce_pkg::ST_Z] = (xr == 20'h00000);
            st_nxt.status[xce_pkg::ST_C] = (xr != 20'h00000);
            st_nxt.status[xce_pkg::ST_V] = |(st_r.src & st_r.dst & topbit);
          end
          xce_pkg::OP_ADD: begin
            r = sum[19:0];
            st_nxt.dst = sum[19:0];
            st_nxt.status[xce_pkg::ST_N] = sum[19];
            st_nxt.status[xce_pkg::ST_Z] = (sum[19:0] == 20'h00000);
            st_nxt.status[xce_pkg::ST_C] = sum[20];
            st_nxt.status[xce_pkg::ST_V] = (st_r.src[19] == st_r.dst[19]) &&
                                     (sum[19] != st_r.src[19]);
          end
          xce_pkg::OP_BRANCH, xce_pkg::OP_CALL: begin
            if (tm == xce_pkg::TM_IMM || tm == xce_pkg::TM_REG) begin
              tgt = st_r.src;
            end else begin
              tgt = st_r.tmp;
            end
            st_nxt.tmp = tgt;
            if (op == xce_pkg::OP_BRANCH) begin
              st_nxt.pc = tgt;
            end else begin
              // Target is latched into tmp at the same edge as the first stack step.
              st_nxt.sp = st_r.sp - xce_pkg::WORD_STEP;
              st_nxt.st = xce_pkg::S_PUSH_HI;
              st_nxt.mreq = '{1'b1, 1'b1, st_r.sp - xce_pkg::WORD_STEP,
                              {12'h000, st_r.pc[19:16]}};
            end
          end
          default: r = st_r.res;
        endcase
        st_nxt.res = r;
        // Write back a memory destination for sign extend and XOR.
        if (!reg_dst && (op == xce_pkg::OP_SIGN_EXT ||
                         op == xce_pkg::OP_XOR)) begin
          st_nxt.st = xce_pkg::S_WR_LO;
          st_nxt.mreq = '{1'b1, 1'b1, st_r.ptr, r[15:0]};
          if (sz == xce_pkg::SZ_BYTE) begin
            // A byte destination keeps the other byte of its word.
            st_nxt.mreq.wdata[15:8] = st_r.dst[15:8];
          end
        end else if (op == xce_pkg::OP_SIGN_EXT || op == xce_pkg::OP_XOR) begin
          st_nxt.dst = r;
        end
        if (zf) begin
          st_nxt.res = 20'h00000;
        end
      end
      xce_pkg::S_WR_LO: begin
        if (mem_rsp.ack) begin
          st_nxt.st = xce_pkg::S_IDLE;
          if (sz == xce_pkg::SZ_ADDR) begin
            // Bits 31:20 of the following word are cleared.
            st_nxt.st = xce_pkg::S_WR_HI;
            st_nxt.mreq = '{1'b1, 1'b1, st_r.ptr + xce_pkg::WORD_STEP,
                            {12'h000, st_r.res[19:16]}};
          end
        end
      end
      xce_pkg::S_WR_HI: begin
        if (mem_rsp.ack) begin
          st_nxt.st = xce_pkg::S_IDLE;
        end
      end
      xce_pkg::S_PUSH_HI: begin
        if (mem_rsp.ack) begin
          st_nxt.sp = st_r.sp - xce_pkg::WORD_STEP;
          st_nxt.st = xce_pkg::S_PUSH_LO;
          st_nxt.mreq = '{1'b1, 1'b1, st_r.sp - xce_pkg::WORD_STEP,
                          st_r.pc[15:0]};
        end
      end
      xce_pkg::S_PUSH_LO: begin
        if (mem_rsp.ack) begin
          st_nxt.pc = st_r.tmp;
          st_nxt.st = xce_pkg::S_IDLE;
        end
      end
      xce_pkg::S_POP_LO: begin
        if (mem_rsp.ack) begin
          st_nxt.pc[15:0] = mem_rsp.rdata;
          st_nxt.sp = st_r.sp + xce_pkg::WORD_STEP;
          st_nxt.st = xce_pkg::S_POP_HI;
          st_nxt.mreq = '{1'b1, 1'b0, st_r.sp + xce_pkg::WORD_STEP, 16'h0000};
        end
      end
      xce_pkg::S_POP_HI: begin
        if (mem_rsp.ack) begin
          st_nxt.pc[19:16] = mem_rsp.rdata[3:0];
          st_nxt.sp = st_r.sp + xce_pkg::WORD_STEP;
          st_nxt.st = xce_pkg::S_IDLE;
        end
      end
      default: st_nxt.st = xce_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.pc <= xce_pkg::PC_RST;
      st_r.sp <= xce_pkg::SP_RST;
      st_r.status <= xce_pkg::STATUS_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // A read gets one wait state so that its data come from a flip-flop
  // while hready is high; writes have none. The answer is always OKAY.
  assign hreadyout = !(st_r.ap_valid && !st_r.ap_write);
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign mem_req = st_r.mreq;
  assign busy = (st_r.st != xce_pkg::S_IDLE);
endmodule : xce_exec

// >>> pkg/xce_pkg.sv
// Constants, opcodes and carrier types for the extended execution unit.
// Assumes a 20-bit data path, a 16-bit memory port and a 32-bit AHB-Lite bus.
// Summary of operation
// - Address-word sign extend in memory: bit 7 to 19:8, clear 31:20.
// - Word sign extend in memory: bit 7 copied into bits 15:8.
// - Sign extend flags: N, Z from result, C is not Z, V cleared.
// - Test: destination plus all-ones plus one, unchanged, N Z set, C set.
// - Exclusive OR writes src xor dst at chosen width, source unchanged.
// - XOR flags: N top bit, Z zero, C not Z, V both negative.
// - Word XOR into a register clears register bits 19:16.
// - Address instructions use 20-bit register or immediate sources, or a memory target for branch and call.
// - Register add sums source into destination register, source kept.
// - Register add: N is bit 19, Z on zero, C on carry out.
// - Register add: V on same-sign operands giving opposite-sign result.
// - Branch loads 20-bit target into PC, any of seven modes, flags kept.
// - Memory target: low word at address, upper bits at address plus two.
// - Auto-increment target mode adds four to the pointer afterwards.
// - Indexed and symbolic targets use a signed 16-bit offset.
// - Call: target to temp, push PC 19:16, then PC 15:0, then load.
// - Call uses two stack words, keeps flags, pairs with return.
// - Return pops low word then upper bits, status bits kept.
// - Register sign extend copies bit 7 into bits 19:8.
package xce_pkg;
  // Register offsets (byte addresses).
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_RES = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PC = 8'h14;
  localparam logic [7:0] OFS_SP = 8'h18;
  localparam logic [7:0] OFS_PTR = 8'h1C;
  // Control register fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SIZE_LSB = 4;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_REGDST_BIT = 12;
  localparam int CTRL_OFS_LSB = 16;
  // Status register bit positions.
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_GIE = 3;
  localparam int ST_CORE_OFF_BIT = 4;
  localparam int ST_OSCILLATOR_OFF_BIT = 5;
  localparam int ST_V = 8;
  // Reset values.
  localparam logic [19:0] PC_RST = 20'h00000;
  localparam logic [19:0] SP_RST = 20'h00A00;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // Stack and pointer steps in bytes.
  localparam logic [19:0] WORD_STEP = 20'h00002;
  localparam logic [19:0] PTR_STEP = 20'h00004;
  localparam logic [19:0] ALL_ONES20 = 20'hFFFFF;
  localparam logic [31:0] BUS_UNMAPPED = 32'h00000000;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_SIGN_EXT = 4'b0001,
    OP_TEST = 4'b0010,
    OP_XOR = 4'b0011,
    OP_ADD = 4'b0100,
    OP_BRANCH = 4'b0101,
    OP_CALL = 4'b0110,
    OP_RETURN = 4'b0111
  } xce_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_ADDR = 2'b10
  } xce_size_t;

  // Seven target modes of branch and call.
  typedef enum logic [2:0] {
    TM_IMM = 3'b000,
    TM_REG = 3'b001,
    TM_INDIRECT = 3'b010,
    TM_AUTOINC = 3'b011,
    TM_INDEXED = 3'b100,
    TM_SYMBOLIC = 3'b101,
    TM_ABSOLUTE = 3'b110
  } xce_tmode_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_RD_LO = 4'b0001,
    S_RD_HI = 4'b0010,
    S_EXEC = 4'b0011,
    S_WR_LO = 4'b0100,
    S_WR_HI = 4'b0101,
    S_PUSH_HI = 4'b0110,
    S_PUSH_LO = 4'b0111,
    S_POP_LO = 4'b1000,
    S_POP_HI = 4'b1001
  } xce_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [19:0] addr;
    logic [15:0] wdata;
  } xce_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } xce_mem_rsp_t;
endpackage : xce_pkg

// >>> test/extended_cpu_instruction_exec_test.sv
// Self-checking bench for the extended execution unit over AHB-Lite.
// Assumes the behavioural memory model on the memory port.
`timescale 1ns/1ps
module extended_cpu_instruction_exec_test;
  logic hclk;
  logic hresetn;
  logic clk_en;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic busy;
  logic [3:0] wait_cyc;
  xce_pkg::xce_mem_req_t mem_req;
  xce_pkg::xce_mem_rsp_t mem_rsp;
  int error_cnt = 0;
  int check_count = 0;
  xce_exec dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy));
  xce_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .wait_cyc(wait_cyc));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // Read data are taken at the edge that ends the data phase.
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask : rc
  function automatic logic [31:0] cw(input logic [3:0] o,
      input logic [1:0] s, input logic [2:0] m, input logic r,
      input logic [15:0] x);
    cw = {x, 3'h0, r, 1'h0, m, 2'h0, s, o};
  endfunction : cw
  task automatic op(input logic [31:0] c);
    wr(xce_pkg::OFS_CTRL, c);
    // Busy rises only after the edge that ends the control write.
    @(posedge hclk);
    while (busy !== 1'b0) begin
      @(posedge hclk);
    end
  endtask : op
  // Presetting every flag to its opposite shows a flag that never updates.
  task automatic alu(input logic [31:0] c, input logic [31:0] s,
      input logic [31:0] d, input logic [31:0] r, input logic [31:0] st);
    wr(xce_pkg::OFS_SRC, s);
    wr(xce_pkg::OFS_DST, d);
    wr(xce_pkg::OFS_STATUS, st ^ 32'h00000107);
    op(c);
    if (r !== 32'hFFFFFFFF) rc(xce_pkg::OFS_RES, r);
    rc(xce_pkg::OFS_STATUS, st);
    rc(xce_pkg::OFS_SRC, s);
  endtask : alu
  task automatic mop(input logic [31:0] c, input logic [31:0] p,
      input logic [31:0] st);
    wr(xce_pkg::OFS_PTR, p);
    wr(xce_pkg::OFS_STATUS, st ^ 32'h00000107);
    op(c);
    rc(xce_pkg::OFS_STATUS, st);
  endtask : mop
  task automatic br(input logic [2:0] m, input logic [31:0] s,
      input logic [31:0] p, input logic [15:0] x, input logic [31:0] pc);
    wr(xce_pkg::OFS_SRC, s);
    wr(xce_pkg::OFS_PTR, p);
    wr(xce_pkg::OFS_PC, 32'h00000100);
    op(cw(4'h5, 2'h2, m, 1'b0, x));
    rc(xce_pkg::OFS_PC, pc);
  endtask : br
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'b010;
    clk_en = 1'b1;
    wait_cyc = 4'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rc(xce_pkg::OFS_PC, 32'h00000000);
    rc(xce_pkg::OFS_SP, 32'h00000A00);
    rc(xce_pkg::OFS_STATUS, 32'h00000000);
    rc(8'h40, 32'h00000000);
    alu(cw(4'h1, 2'h2, 3'h1, 1'b1, 16'h0), 0, 32'h80, 32'hFFF80, 32'h3D);
    mem_u.mem[9'h080] = 16'h0085;
    mem_u.mem[9'h081] = 16'h1234;
    mem_u.mem[9'h082] = 16'h1200;
    mop(cw(4'h1, 2'h2, 3'h2, 1'b0, 16'h0), 32'h100, 32'h3D);
    chk({16'h0, mem_u.mem[9'h080]}, 32'h0000FF85);
    chk({16'h0, mem_u.mem[9'h081]}, 32'h0000000F);
    mop(cw(4'h1, 2'h1, 3'h2, 1'b0, 16'h0), 32'h104, 32'h3A);
    chk({16'h0, mem_u.mem[9'h082]}, 32'h00000000);
    mem_u.mem[9'h083] = 16'hA55A;
    wr(xce_pkg::OFS_SRC, 32'h00F0F);
    mop(cw(4'h3, 2'h0, 3'h0, 1'b0, 16'h0), 32'h106, 32'h39);
    chk({16'h0, mem_u.mem[9'h083]}, 32'h0000A555);
    alu(cw(4'h2, 2'h0, 3'h1, 1'b1, 16'h0), 0, 32'h80, '1, 32'h3D);
    rc(xce_pkg::OFS_DST, 32'h80);
    alu(cw(4'h2, 2'h1, 3'h1, 1'b1, 16'h0), 0, 32'h10000, '1, 32'h3B);
    rc(xce_pkg::OFS_DST, 32'h10000);
    alu(cw(4'h2, 2'h2, 3'h1, 1'b1, 16'h0), 0, 32'h1, '1, 32'h39);
    rc(xce_pkg::OFS_DST, 32'h1);
    alu(cw(4'h3, 2'h1, 3'h0, 1'b1, 16'h0), 32'h8001, 32'hF8000, 32'h1, 32'h139);
    alu(cw(4'h3, 2'h0, 3'h0, 1'b1, 16'h0), 32'h80, 32'h80, 32'h0, 32'h13A);
    alu(cw(4'h3, 2'h2, 3'h0, 1'b1, 16'h0), 32'h80000, 32'h1, 32'h80001, 32'h3D);
    alu(cw(4'h4, 2'h2, 3'h0, 1'b1, 16'h0), 32'h7FFFF, 32'h1, 32'h80000, 32'h13C);
    alu(cw(4'h4, 2'h2, 3'h0, 1'b1, 16'h0), 32'hFFFFF, 32'h1, 32'h0, 32'h3B);
    alu(cw(4'h4, 2'h2, 3'h1, 1'b1, 16'h0), 32'h80000, 32'h80000, 32'h0, 32'h13B);
    mem_u.mem[9'h100] = 16'h5678;
    mem_u.mem[9'h101] = 16'h0009;
    mem_u.mem[9'h102] = 16'hBCDE;
    mem_u.mem[9'h103] = 16'h000E;
    wait_cyc <= 4'h2;
    br(3'h0, 32'h1AA04, 0, 16'h0, 32'h1AA04);
    br(3'h1, 32'h2BB06, 0, 16'h0, 32'h2BB06);
    br(3'h2, 0, 32'h200, 16'h0, 32'h95678);
    br(3'h3, 0, 32'h200, 16'h0, 32'h95678);
    rc(xce_pkg::OFS_PTR, 32'h204);
    br(3'h4, 0, 32'h208, 16'hFFF8, 32'h95678);
    br(3'h5, 0, 0, 16'h0104, 32'hEBCDE);
    br(3'h6, 32'h204, 0, 16'h0, 32'hEBCDE);
    rc(xce_pkg::OFS_STATUS, 32'h13B);
    wr(xce_pkg::OFS_PC, 32'h3ABCD);
    wr(xce_pkg::OFS_SRC, 32'h01000);
    op(cw(4'h6, 2'h2, 3'h0, 1'b0, 16'h0));
    rc(xce_pkg::OFS_PC, 32'h01000);
    rc(xce_pkg::OFS_SP, 32'h009FC);
    chk({16'h0, mem_u.mem[9'h0FF]}, 32'h00000003);
    chk({16'h0, mem_u.mem[9'h0FE]}, 32'h0000ABCD);
    rc(xce_pkg::OFS_STATUS, 32'h13B);
    op(cw(4'h7, 2'h2, 3'h0, 1'b0, 16'h0));
    rc(xce_pkg::OFS_PC, 32'h3ABCD);
    rc(xce_pkg::OFS_SP, 32'h00A00);
    rc(xce_pkg::OFS_STATUS, 32'h13B);
    op(32'h00000000);
    rc(xce_pkg::OFS_PC, 32'h3ABCD);
    wrap_up();
  end
endmodule : extended_cpu_instruction_exec_test

// >>> test/xce_exec_chk.sv
// Concurrent checks on the ports of the extended execution unit.
// Assumes one clock, an asynchronous active-low reset and one AHB master.
`timescale 1ns/1ps
module xce_exec_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // Memory side and status
  input wire xce_pkg::xce_mem_req_t mem_req,
  input wire xce_pkg::xce_mem_rsp_t mem_rsp,
  input wire logic busy
);
  logic ctl_take;
  logic ctl_ph;
  logic rd_seen;
  logic wr_seen;
  logic [3:0] op_r;
  logic [3:0] rd_hist;
  logic [19:0] rd_addr;
  logic [19:0] wr_addr;
  assign ctl_take = hsel && htrans[1] && hready && hwrite &&
    (haddr[7:0] == xce_pkg::OFS_CTRL) && !busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ctl_ph, rd_seen, wr_seen, op_r, rd_hist, rd_addr, wr_addr} <= '0;
    end else begin
      ctl_ph <= ctl_take;
      rd_hist <= {rd_hist[2:0], hsel && htrans[1] && hready && !hwrite};
      if (ctl_ph) op_r <= hwdata[3:0];
      if (!busy) begin
        rd_seen <= 1'b0;
        wr_seen <= 1'b0;
      end else if (mem_req.req && mem_rsp.ack) begin
        rd_seen <= !mem_req.we;
        wr_seen <= mem_req.we;
        if (mem_req.we) wr_addr <= mem_req.addr;
        else rd_addr <= mem_req.addr;
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence ctl_go_s;
    ctl_take ##1 (hwdata[3:0] != 4'h0 && hwdata[3:0] <= 4'h7);
  endsequence
  sequence ctl_nop_s;
    ctl_take ##1 (hwdata[3:0] == 4'h0);
  endsequence
  a_read_wait: assert property (!hreadyout |->
    $past(hsel && htrans[1] && hready && !hwrite) ##1 hreadyout)
    else $error("wait state outside a read data phase");
  a_busy_starts: assert property (ctl_go_s |-> ##[0:3] busy)
    else $error("operation did not start");
  a_nop_idle: assert property (ctl_nop_s |-> ##1 (!busy) [*3])
    else $error("empty operation set busy");
  a_rdata_holds: assert property (!$stable(hrdata) |-> rd_hist != 4'h0)
    else $error("read data changed without a read");
  a_req_stands: assert property (mem_req.req && !mem_rsp.ack |=>
    mem_req.req && $stable(mem_req))
    else $error("memory request dropped before ack");
  a_read_pair: assert property (mem_req.req && !mem_req.we && rd_seen
    |-> mem_req.addr == rd_addr + 20'h00002)
    else $error("upper word not read at address plus two");
  a_push_hi: assert property (mem_req.req && mem_req.we &&
    op_r == 4'h6 && !wr_seen |-> mem_req.wdata[15:4] == 12'h000)
    else $error("first push is not the upper bits");
  a_push_lo: assert property (mem_req.req && mem_req.we &&
    op_r == 4'h6 && wr_seen |-> mem_req.addr == wr_addr - 20'h00002)
    else $error("second push not one word lower");
endmodule : xce_exec_chk

bind xce_exec xce_exec_chk chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .busy(busy));

// >>> test/xce_mem_model.sv
// Behavioural 16-bit program and data memory for the execution unit.
// Assumes one request at a time, held until the ack pulse.
`timescale 1ns/1ps
module xce_mem_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request and answer
  input wire xce_pkg::xce_mem_req_t mem_req,
  output xce_pkg::xce_mem_rsp_t mem_rsp,
  // Cycles to wait before each ack
  input wire logic [3:0] wait_cyc
);
  // Only address bits 9:1 decode, so the bench keeps its data apart there.
  logic [15:0] mem [0:511];
  logic [3:0] cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      mem_rsp <= '0;
    end else if (mem_req.req && !mem_rsp.ack && cnt >= wait_cyc) begin
      cnt <= 4'h0;
      mem_rsp.ack <= 1'b1;
      mem_rsp.rdata <= mem[mem_req.addr[9:1]];
      if (mem_req.we) mem[mem_req.addr[9:1]] <= mem_req.wdata;
    end else begin
      cnt <= mem_req.req ? cnt + 4'h1 : 4'h0;
      mem_rsp.ack <= 1'b0;
      // Read data is not valid outside ack, so it keeps moving.
      mem_rsp.rdata <= ~mem_rsp.rdata;
    end
  end
endmodule : xce_mem_model
